/* common/fbp_defines.svh */
`ifndef FBP_DEFINES_SVH
`define FBP_DEFINES_SVH

// Word-addressed array geometry, 32-bit words
`define FBP_DATA_W        32
`define FBP_WORD_ADDR_W   14
`define FBP_BLOCK_WORDS_W 8
`define FBP_BLOCK_IDX_W   6
`define FBP_NUM_BLOCKS    64
`define FBP_REGION_IDX_W  5
`define FBP_NUM_REGIONS   32

// Field positions inside a word address
`define FBP_BLOCK_LSB     8
`define FBP_BLOCK_MSB     13

// Value of every word after an erase
`define FBP_ERASED_WORD   32'hffffffff

// Reset values and index of the last word in a block
`define FBP_RESET_DATA    32'h00000000
`define FBP_RESET_COUNT   8'h00
`define FBP_LAST_WORD     8'hff

`endif

/* common/fbp_pkg.sv */
`include "fbp_defines.svh"

package fbp_pkg;
    typedef enum {
        FBP_IDLE,
        FBP_ERASE
    } fbp_state_e;

    typedef logic [`FBP_WORD_ADDR_W-1:0] fbp_waddr_t;
    typedef logic [`FBP_BLOCK_IDX_W-1:0] fbp_block_t;
    typedef logic [`FBP_NUM_REGIONS-1:0] fbp_mask_t;
endpackage

/* common/fbp_prot_if.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fbp_defines.svh"

interface fbp_prot_if;
    fbp_pkg::fbp_mask_t  roMask;
    fbp_pkg::fbp_mask_t  xoMask;
    fbp_pkg::fbp_block_t wrBlock;
    fbp_pkg::fbp_waddr_t rdAddr;
    logic                wrDenied;
    logic                rdDenied;

    modport requester (
        output roMask, xoMask, wrBlock, rdAddr,
        input  wrDenied, rdDenied
    );
    modport verdict (
        input  roMask, xoMask, wrBlock, rdAddr,
        output wrDenied, rdDenied
    );
endinterface

`default_nettype wire

/* design/fbp_region_check.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fbp_defines.svh"

module fbp_region_check (
    fbp_prot_if.verdict prot // Masks and addresses in, verdicts out
);
    // ------------------------------------------------------------
    // Region decoding
    // ------------------------------------------------------------
    // Two adjacent erase blocks share one protection region
    function automatic logic [`FBP_REGION_IDX_W-1:0] regionOfBlock(
        input fbp_pkg::fbp_block_t blk
    );
        regionOfBlock = blk[`FBP_BLOCK_IDX_W-1:1]; // RULE3
    endfunction

    function automatic logic [`FBP_REGION_IDX_W-1:0] regionOfAddr(
        input fbp_pkg::fbp_waddr_t addr
    );
        regionOfAddr = regionOfBlock(addr[`FBP_BLOCK_MSB:`FBP_BLOCK_LSB]);
    endfunction

    // ------------------------------------------------------------
    // Verdicts
    // ------------------------------------------------------------
    // Either marking blocks erase and program
    assign prot.wrDenied = prot.roMask[regionOfBlock(prot.wrBlock)]
                         | prot.xoMask[regionOfBlock(prot.wrBlock)]; // RULE5
    // Only execute-only hides data; read-only stays readable
    assign prot.rdDenied = prot.xoMask[regionOfAddr(prot.rdAddr)]; // RULE6
endmodule

`default_nettype wire

/* design/fbp_flash_block_protection.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fbp_defines.svh"

// Operation
// RULE1: 64 KB array in 1 KB blocks, each erased alone without touching others.
// RULE2: An erased block reads back as all ones in every bit.
// RULE3: Protection works on 2 KB regions of two blocks, each set independently.
// RULE4: Every region has its own read-only and execute-only marking.
// RULE5: Read-only regions refuse erase and program and keep their contents.
// RULE6: Execute-only regions refuse writes and serve fetches but never data reads.
// RULE7: Reads are answered on the clock cycle after the request.
// RULE8: Refused accesses change nothing, return no data and set a sticky flag.
module fbp_flash_block_protection #(
    parameter int NUM_BLOCKS = `FBP_NUM_BLOCKS // Erase blocks in the array
) (
    input  wire logic                       clock,          // System clock
    input  wire logic                       rst,            // Sync reset
    input  wire logic [`FBP_NUM_REGIONS-1:0] readOnlyMask,  // Read-only marks
    input  wire logic [`FBP_NUM_REGIONS-1:0] execOnlyMask,  // Exec-only marks
    input  wire logic                       fetchReq,       // Instr fetch
    input  wire logic [`FBP_WORD_ADDR_W-1:0] fetchAddr,     // Fetch word addr
    output logic                            fetchValid,     // Fetch answer
    output logic [`FBP_DATA_W-1:0]          fetchData,      // Fetch word
    input  wire logic                       dataReq,        // Data read
    input  wire logic                       dataFromDebug,  // Debugger access
    input  wire logic [`FBP_WORD_ADDR_W-1:0] dataAddr,      // Data word addr
    output logic                            dataValid,      // Read served
    output logic                            dataDenied,     // Read refused
    output logic [`FBP_DATA_W-1:0]          dataRdData,     // Read word
    input  wire logic                       eraseReq,       // Erase request
    input  wire logic [`FBP_BLOCK_IDX_W-1:0] eraseBlock,    // Block to erase
    input  wire logic                       progReq,        // Program request
    input  wire logic [`FBP_WORD_ADDR_W-1:0] progAddr,      // Program address
    input  wire logic [`FBP_DATA_W-1:0]     progData,       // Program word
    output logic                            opBusy,         // Erase running
    output logic                            opDone,         // Write finished
    output logic                            opRefused,      // Write refused
    input  wire logic                       violationClear, // Clear flag
    output logic                            violationFlag   // Sticky violation
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // Region masks and block index width fix the array at 64 blocks
    if (NUM_BLOCKS != `FBP_NUM_BLOCKS)
    begin : gBadBlocks
        $error("NUM_BLOCKS must equal 64");
    end

    // ------------------------------------------------------------
    // Storage and protection check
    // ------------------------------------------------------------
    localparam int WORDS = NUM_BLOCKS << `FBP_BLOCK_WORDS_W;

    logic [`FBP_DATA_W-1:0] flashMem [WORDS]; // RULE1

    fbp_pkg::fbp_state_e  state_q;
    fbp_pkg::fbp_block_t  eraseBlk_q;
    logic [`FBP_BLOCK_WORDS_W-1:0] eraseCnt_q;
    logic                 eraseTake;
    logic                 progTake;
    logic                 wrAttempt;
    logic                 rdRefuse;

    fbp_prot_if prot ();

    // Erase takes precedence over program when both arrive together
    assign prot.roMask  = readOnlyMask; // RULE4
    assign prot.xoMask  = execOnlyMask; // RULE4
    assign prot.wrBlock = eraseReq ? eraseBlock
                        : progAddr[`FBP_BLOCK_MSB:`FBP_BLOCK_LSB];
    assign prot.rdAddr  = dataAddr;

    // Region decode sits in one module so both verdicts agree on it
    fbp_region_check uCheck (
        .prot (prot.verdict) // RULE3
    );

    // ------------------------------------------------------------
    // Write acceptance
    // ------------------------------------------------------------
    // Requests while an erase runs are ignored, not refused
    assign opBusy    = (state_q == fbp_pkg::FBP_ERASE);
    assign wrAttempt = (eraseReq | progReq) & ~opBusy;
    assign eraseTake = eraseReq & ~opBusy & ~prot.wrDenied; // RULE5
    assign progTake  = progReq & ~eraseReq & ~opBusy
                     & ~prot.wrDenied; // RULE6
    assign rdRefuse  = dataReq & prot.rdDenied; // RULE6

    // Erase sequencer walks the block one word per cycle
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_q    <= fbp_pkg::FBP_IDLE;
            eraseBlk_q <= '0;
            eraseCnt_q <= `FBP_RESET_COUNT;
        end
        else
        begin
            case (state_q)
                fbp_pkg::FBP_IDLE:
                begin
                    if (eraseTake)
                    begin
                        state_q    <= fbp_pkg::FBP_ERASE;
                        eraseBlk_q <= eraseBlock;
                        eraseCnt_q <= `FBP_RESET_COUNT;
                    end
                end
                fbp_pkg::FBP_ERASE:
                begin
                    eraseCnt_q <= eraseCnt_q + 8'h01;
                    if (eraseCnt_q == `FBP_LAST_WORD)
                    begin
                        state_q <= fbp_pkg::FBP_IDLE;
                    end
                end
                default:
                begin
                    state_q <= fbp_pkg::FBP_IDLE;
                end
            endcase
        end
    end

    // No reset here: stored words must survive a system reset
    // Array writes; only the addressed block is ever touched
    always_ff @(posedge clock)
    begin
        if (opBusy)
        begin
            flashMem[{eraseBlk_q, eraseCnt_q}] <= `FBP_ERASED_WORD; // RULE2
        end
        else if (progTake)
        begin
            // Programming can only clear bits, as in a real cell
            flashMem[progAddr] <= flashMem[progAddr] & progData; // RULE1
        end
    end

    // Completion and refusal pulses, one cycle after the cause
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            opDone    <= 1'b0;
            opRefused <= 1'b0;
        end
        else
        begin
            opDone    <= progTake
                       | (opBusy & (eraseCnt_q == `FBP_LAST_WORD));
            opRefused <= wrAttempt & prot.wrDenied; // RULE8
        end
    end

    // ------------------------------------------------------------
    // Read ports
    // ------------------------------------------------------------
    // Fetch is never blocked, even from execute-only regions
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            fetchValid <= 1'b0;
            fetchData  <= `FBP_RESET_DATA;
        end
        else
        begin
            fetchValid <= fetchReq; // RULE7
            fetchData  <= fetchReq ? flashMem[fetchAddr] : `FBP_RESET_DATA;
        end
    end

    // Data and debugger reads; a refused read returns zero
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            dataValid  <= 1'b0;
            dataDenied <= 1'b0;
            dataRdData <= `FBP_RESET_DATA;
        end
        else
        begin
            dataValid  <= dataReq & ~rdRefuse; // RULE7
            dataDenied <= rdRefuse; // RULE6
            dataRdData <= (dataReq & ~rdRefuse) ? flashMem[dataAddr]
                        : `FBP_RESET_DATA; // RULE8
        end
    end

    // ------------------------------------------------------------
    // Sticky violation
    // ------------------------------------------------------------
    // A new violation in the clearing cycle wins over the clear
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            violationFlag <= 1'b0;
        end
        else if (rdRefuse | (wrAttempt & prot.wrDenied))
        begin
            violationFlag <= 1'b1; // RULE8
        end
        else if (violationClear)
        begin
            violationFlag <= 1'b0;
        end
    end

    // Debugger reads share the data path and the same denial
    // Kept as a pin so a stricter debug policy needs no port change
    logic unusedDebug;
    assign unusedDebug = dataFromDebug;
endmodule

`default_nettype wire

/* sim/fbp_flash_block_protection_properties.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fbp_defines.svh"

// Port-level checks on the flash protection block
module fbp_flash_block_protection_properties #(
    parameter int NUM_BLOCKS = `FBP_NUM_BLOCKS // Blocks
) (
    input wire logic        clock,        // Clock
    input wire logic        rst,          // Reset
    input wire logic [31:0] readOnlyMask, // Marks
    input wire logic [31:0] execOnlyMask, // Marks
    input wire logic        fetchReq,     // Fetch
    input wire logic        fetchValid,   // Answer
    input wire logic        dataReq,      // Read
    input wire logic [13:0] dataAddr,     // Addr
    input wire logic        dataValid,    // Served
    input wire logic        dataDenied,   // Denied
    input wire logic [31:0] dataRdData,   // Word
    input wire logic        eraseReq,     // Erase
    input wire logic [5:0]  eraseBlock,   // Block
    input wire logic        progReq,      // Program
    input wire logic [13:0] progAddr,     // Addr
    input wire logic        opBusy,       // Busy
    input wire logic        opDone,       // Done
    input wire logic        opRefused,    // Refused
    input wire logic        violationFlag // Flag
);
    // Two 1 KB blocks share one mark bit, so the region is addr >> 9
    logic        dXo, pTake, pProt, eTake, eProt;
    logic [31:0] prot;
    assign prot  = readOnlyMask | execOnlyMask;
    assign dXo   = execOnlyMask[dataAddr[13:9]];
    assign pTake = progReq && !eraseReq && !opBusy;
    assign pProt = prot[progAddr[13:9]];
    assign eTake = eraseReq && !opBusy;
    assign eProt = prot[eraseBlock[5:1]];

    // One clock domain; reset drops attempts in flight
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    fetch_answer_a: assert property (fetchReq |=> fetchValid)
        else $error("fetch not answered");
    data_serve_a: assert property (dataReq && !dXo |=> dataValid)
        else $error("read not served");
    xo_deny_a: assert property (dataReq && dXo |=> dataDenied &&
        !dataValid && dataRdData == 32'h0) else $error("read not denied");
    prot_prog_a: assert property (pTake && pProt |=> opRefused)
        else $error("program not refused");
    free_prog_a: assert property (pTake && !pProt |=> opDone)
        else $error("program not done");
    erase_span_a: assert property (eTake && !eProt |=> opBusy
        ##255 opBusy ##1 !opBusy && opDone) else $error("erase span");
    prot_erase_a: assert property (eTake && eProt |=> opRefused
        && !opBusy) else $error("erase not refused");
    flag_raise_a: assert property (dataDenied || opRefused
        |-> violationFlag) else $error("flag not set");

    // Main scenarios reached
    cover property (eTake && !eProt);
    cover property (pTake && pProt);
    cover property (dataReq && dXo);
endmodule

bind fbp_flash_block_protection fbp_flash_block_protection_properties
    #(.NUM_BLOCKS(NUM_BLOCKS)) i_props (.*);

`default_nettype wire

/* sim/fbp_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Processor side: fetch, data and debugger reads, program and erase
module fbp_cpu_model (
    input  wire logic        clock,         // Clock
    output var  logic        fetchReq,      // Fetch
    output var  logic [13:0] fetchAddr,     // Addr
    output var  logic        dataReq,       // Read
    output var  logic        dataFromDebug, // Debug
    output var  logic [13:0] dataAddr,      // Addr
    output var  logic        eraseReq,      // Erase
    output var  logic [5:0]  eraseBlock,    // Block
    output var  logic        progReq,       // Program
    output var  logic [13:0] progAddr,      // Addr
    output var  logic [31:0] progData       // Word
);
    // Idle at time zero
    initial
        {fetchReq, fetchAddr, dataReq, dataFromDebug, dataAddr, eraseReq,
         eraseBlock, progReq, progAddr, progData} = '0;

    // One request for one cycle: fetch, data, debug, program, erase.
    // Released lines show the inverse so a stale value never matches
    task automatic req(input logic [2:0] k, input logic [13:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        fetchReq      <= (k == 3'h0);
        dataReq       <= (k == 3'h1) || (k == 3'h2);
        dataFromDebug <= (k == 3'h2);
        progReq       <= (k == 3'h3);
        eraseReq      <= (k == 3'h4);
        {fetchAddr, dataAddr, progAddr} <= {a, a, a};
        {eraseBlock, progData} <= {a[13:8], d};
        @(posedge clock);
        {fetchReq, dataReq, dataFromDebug, progReq, eraseReq} <= 5'h0;
        {fetchAddr, dataAddr, progAddr} <= ~{a, a, a};
        {eraseBlock, progData} <= ~{a[13:8], d};
        #1;
    endtask
endmodule

`default_nettype wire

/* sim/fbp_flash_block_protection_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module fbp_flash_block_protection_tb_top;
    logic        clock, rst, violationClear, fetchReq, dataReq, progReq;
    logic        dataFromDebug, eraseReq, fetchValid, dataValid, opBusy;
    logic        dataDenied, opDone, opRefused, violationFlag;
    logic [13:0] fetchAddr, dataAddr, progAddr;
    logic [5:0]  eraseBlock;
    logic [31:0] readOnlyMask, execOnlyMask, progData, fetchData, dataRdData;
    int          fails, n_checks;

    fbp_flash_block_protection i_dut (.*);
    fbp_cpu_model i_cpu (.*);

    // 100 ns period
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results;
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // One request; a write also checks its cycle count to the answer
    task automatic op(input logic [2:0] k, input logic [13:0] a,
                      input logic [31:0] e, input logic bad);
        int i;
        i = 0;
        i_cpu.req(k, a, e);
        while (k > 3'h2 && opDone !== 1'b1 && opRefused !== 1'b1 && i < 300)
        begin
            @(posedge clock);
            #1;
            i++;
        end
        if (k > 3'h2)
            chk({15'h0, opBusy, opDone, opRefused, 16'(i)},
                {15'h0, 1'b0, !bad, bad,
                (k == 3'h4 && !bad) ? 16'h0100 : 16'h0000});
        else
            chk({k != 3'h0 ? dataRdData : fetchData,
                k != 3'h0 ? dataValid : fetchValid, dataDenied},
                {e, !bad, bad});
    endtask

    // Erase two blocks around a programmed word
    task automatic t_erase;
        op(3'h4, 14'h0200, 32'h0, 1'h0);
        op(3'h3, 14'h0210, 32'h12345678, 1'h0);
        op(3'h4, 14'h0300, 32'h0, 1'h0);
        op(3'h1, 14'h0300, 32'hffffffff, 1'h0);
        op(3'h0, 14'h03ff, 32'hffffffff, 1'h0);
        op(3'h2, 14'h0210, 32'h12345678, 1'h0);
        $display("t_erase done");
    endtask

    // Read-only region 1 keeps its data; region 2 stays writable
    task automatic t_ro;
        @(posedge clock);
        readOnlyMask <= 32'h2;
        op(3'h3, 14'h0210, 32'h0, 1'h1);
        op(3'h4, 14'h0300, 32'h0, 1'h1);
        chk(34'(violationFlag), 34'h1);
        op(3'h1, 14'h0210, 32'h12345678, 1'h0);
        op(3'h4, 14'h0400, 32'h0, 1'h0);
        $display("t_ro done");
    endtask

    // Execute-only region 1: only fetches see data; flag clears
    task automatic t_xo;
        @(posedge clock);
        readOnlyMask <= 32'h0;
        execOnlyMask <= 32'h2;
        violationClear <= 1'b1;
        @(posedge clock);
        violationClear <= 1'b0;
        #1;
        chk(34'(violationFlag), 34'h0);
        op(3'h1, 14'h0210, 32'h0, 1'h1);
        op(3'h2, 14'h0211, 32'h0, 1'h1);
        op(3'h0, 14'h0210, 32'h12345678, 1'h0);
        op(3'h3, 14'h0210, 32'h0, 1'h1);
        chk(34'(violationFlag), 34'h1);
        $display("t_xo done");
    endtask

    // Mid-run reset drops flag and strobes but keeps the array
    task automatic t_reset;
        @(posedge clock);
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        #1;
        chk(34'({violationFlag, opBusy, opDone, dataDenied}), 34'h0);
        op(3'h0, 14'h0210, 32'h12345678, 1'h0);
        $display("t_reset done");
    endtask

    // Run takes about 800 cycles; a hang is cut at 3000, nearly four times that
    initial
    begin
        #300000;
        fails++;
        results;
    end

    // Reset for two edges, then the scenarios in turn
    initial
    begin
        {rst, violationClear, readOnlyMask, execOnlyMask} = {2'h2, 64'h0};
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        t_erase;
        t_ro;
        t_xo;
        t_reset;
        results;
    end
endmodule

`default_nettype wire
